// file: dv/dahrp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dahrp_dev_model
   import dahrp_pkg::*;
#(
   parameter int unsigned N_DEV = 2
) (
   input wire logic              conv_n_in,
   input wire logic              read_n_in,
   input wire logic [N_DEV-1:0]  cs_n_in,
   input wire logic              pair_in,
   input wire logic [DATA_W-1:0] ain_in [4],
   output logic                  busy_out,
   output logic [DATA_W-1:0]     data_out
);
   logic [DATA_W-1:0] held [4]; // Samples frozen at start
   logic              second;   // Next read gives second input
   initial begin
      busy_out = 1'b0;
      data_out = '0;
      second = 1'b0;
   end
   // Freeze inputs, then convert for a fixed time
   always @(negedge conv_n_in) begin
      held = ain_in;
      second = 1'b0;
      busy_out = 1'b1;
      #(CONV_TIME_NS) busy_out = 1'b0;
   end
   // Drive a result while selected, else scramble the bus
   always @(read_n_in or cs_n_in or second) begin
      if (!read_n_in && !(&cs_n_in)) data_out = held[{pair_in, second}];
      else data_out = ~data_out;
   end
   // End of a read moves to the second result
   always @(posedge read_n_in) begin
      if (!busy_out) second = 1'b1;
   end
endmodule
`default_nettype wire

// file: dv/dahrp_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dahrp_host_sva
   import dahrp_pkg::*;
#(
   parameter int unsigned N_DEV = 2
) (
   input wire logic             sys_clk_in,
   input wire logic             rst_in,
   input wire logic             busy_in,
   input wire logic             conversion_start_n_out,
   input wire logic             read_n_out,
   input wire logic [N_DEV-1:0] chip_select_n_out,
   input wire logic             pair_select_out,
   input wire logic             transfer_acknowledge_n_out,
   input wire logic             result_valid_out,
   input wire logic             ready_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   logic [4:0] quiet_r; // Cycles since read strobe was low
   // Saturating count of read-free cycles
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) quiet_r <= 5'h1f;
      else if (!read_n_out) quiet_r <= 5'h00;
      else if (quiet_r != 5'h1f) quiet_r <= quiet_r + 5'h01;
   end
   sequence s_start;
      $fell(conversion_start_n_out);
   endsequence
   sequence s_read;
      $fell(read_n_out);
   endsequence
   chk_start_width: assert property (s_start |-> (!conversion_start_n_out)[*5] ##1 conversion_start_n_out)
      else $error("start pulse width wrong");
   chk_read_width: assert property (s_read |-> (!read_n_out)[*6] ##1 read_n_out)
      else $error("read strobe width wrong");
   chk_start_taken: assert property (s_start |-> $past(ready_out))
      else $error("start launched while not idle");
   chk_busy_ready: assert property (!conversion_start_n_out |-> !ready_out && read_n_out)
      else $error("idle or reading during start pulse");
   chk_no_busy_read: assert property (s_read |-> !busy_in)
      else $error("read begun during conversion");
   chk_cs_read: assert property (read_n_out == (&chip_select_n_out) && $onehot0(~chip_select_n_out))
      else $error("chip select not paired with read");
   chk_ack_cs: assert property (transfer_acknowledge_n_out == (&chip_select_n_out))
      else $error("acknowledge does not follow chip select");
   chk_pair_held: assert property (!ready_out && $past(!ready_out) |-> $stable(pair_select_out))
      else $error("pair select moved during sequence");
   chk_valid_pulse: assert property (result_valid_out |=> !result_valid_out)
      else $error("valid longer than one cycle");
   chk_read_guard: assert property (s_start |-> quiet_r >= 5'h10)
      else $error("start too soon after read");
endmodule
bind dahrp_host dahrp_host_sva #(.N_DEV(N_DEV)) chk_u (.sys_clk_in, .rst_in, .busy_in, .conversion_start_n_out,
   .read_n_out, .chip_select_n_out, .pair_select_out, .transfer_acknowledge_n_out, .result_valid_out, .ready_out);
`default_nettype wire

// file: dv/dual_adc_host_read_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_adc_host_read_port_tb;
   import dahrp_pkg::*;
   logic              sys_clk_in = 1'b0, rst_in = 1'b1, start_req_in = 1'b0, ext_start_n_in = 1'b1;
   logic              use_fixed_wait_in = 1'b0, pair_sel_in = 1'b0, dev_sel_in = 1'b0;
   logic              busy_in, conv_n, rd_n, psel, ack_n, valid, ready;
   logic [1:0]        cs_n;
   logic [1:0]        cs_seen = 2'h3;   // Chip selects seen during the last read
   logic              dev_conv_n;       // Start pin as the converter sees it
   logic [DATA_W-1:0] data_in, r1, r2;
   logic [DATA_W-1:0] ain [4] = '{default: '0};
   logic [DATA_W-1:0] snap [4];
   int unsigned       rng = 90438;
   int                mismatches = 0, cmp_count = 0;
   always #12.5 sys_clk_in = ~sys_clk_in;
   dahrp_host dut_u (.sys_clk_in, .rst_in, .start_req_in, .ext_start_n_in, .use_fixed_wait_in, .pair_sel_in,
      .dev_sel_in, .busy_in, .data_in, .conversion_start_n_out(conv_n), .read_n_out(rd_n), .chip_select_n_out(cs_n),
      .pair_select_out(psel), .transfer_acknowledge_n_out(ack_n), .result_first_out(r1), .result_second_out(r2),
      .result_valid_out(valid), .ready_out(ready));
   // Board wiring: the external timer and the host start share the start pin
   assign dev_conv_n = conv_n & ext_start_n_in;
   dahrp_dev_model dev_u (.conv_n_in(dev_conv_n), .read_n_in(rd_n), .cs_n_in(cs_n), .pair_in(psel), .ain_in(ain),
      .busy_out(busy_in), .data_out(data_in));
   // Chip selects as the converter sees them during a read
   always @(posedge sys_clk_in) begin
      if (!rd_n) cs_seen <= cs_n;
   end
   ////////////////////////////////////////////////////////////////
   // Xorshift source
   function automatic int unsigned xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // Result expected for a pair and read number
   function automatic logic [DATA_W-1:0] exp_res(logic p, logic sec);
      return snap[{p, sec}];
   endfunction
   task automatic check(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Bounded wait: 0 idle, 1 valid, 2 start low
   task automatic wait_sig(int which);
      int n;
      n = 0;
      while (((which == 0) ? ready : (which == 1) ? valid : !dev_conv_n) !== 1'b1 && n < 900) begin
         @(posedge sys_clk_in);
         n++;
      end
      if (n >= 900) begin
         mismatches++;
         $display("[ERR] wait %0d expected 1 seen timeout", which);
         end_sim();
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // One conversion and result pair; the first four runs pin every mode pair but wait mode with device, both taken from run[1]
   task automatic convert(int run);
      logic       p;
      logic       d;
      logic [1:0] cs_exp;
      wait_sig(0);
      p = (run < 4) ? (run[0] ^ run[1]) : 1'(xs());
      d = (run < 4) ? run[1] : 1'(xs());
      cs_exp = ~(2'h1 << d);
      pair_sel_in <= p;
      dev_sel_in <= d;
      use_fixed_wait_in <= (run < 4) ? run[1] : 1'(xs());
      foreach (ain[i]) ain[i] <= DATA_W'(xs());
      @(posedge sys_clk_in);
      if (run[0]) ext_start_n_in <= 1'b0;
      else start_req_in <= 1'b1;
      wait_sig(2);
      snap = ain;
      foreach (ain[i]) ain[i] <= ~snap[i];
      repeat (8) @(posedge sys_clk_in);
      ext_start_n_in <= 1'b1;
      start_req_in <= 1'b0;
      wait_sig(1);
      check("result_first_out", exp_res(p, 1'b0), r1);
      check("result_second_out", exp_res(p, 1'b1), r2);
      check("pair_select_out", DATA_W'(p), DATA_W'(psel));
      check("chip_select_n_out", DATA_W'(cs_exp), DATA_W'(cs_seen));
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_in);
      check("result_first_out", '0, r1);
      check("read_n_out", DATA_W'(1), DATA_W'(rd_n));
      rst_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      check("ready_out", DATA_W'(1), DATA_W'(ready));
      for (int i = 0; i < 10; i++) convert(i);
      end_sim();
   end
endmodule
`default_nettype wire

// file: hdl/dahrp_host.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Start from user request or external timer
// - Two reads, same address, one result each
// - Derived strobe holds one wait state
// - Host write pulses conversion start low
// - No reads while conversion runs
// - Optional fixed delay instead of busy
// - Chip select echoed as transfer acknowledge
// - Start strobe uses its own decode
// - Shared read strobe, distinct chip selects
// - Reads end 400 ns before next start
module dahrp_host
   import dahrp_pkg::*;
#(
   parameter int unsigned N_DEV = 2,
   parameter int unsigned SEL_W = 1
) (
   input  wire logic              sys_clk_in,
   input  wire logic              rst_in,
   input  wire logic              start_req_in,
   input  wire logic              ext_start_n_in,
   input  wire logic              use_fixed_wait_in,
   input  wire logic              pair_sel_in,
   input  wire logic [SEL_W-1:0]  dev_sel_in,
   input  wire logic              busy_in,
   input  wire logic [DATA_W-1:0] data_in,
   output logic                   conversion_start_n_out,
   output logic                   read_n_out,
   output logic [N_DEV-1:0]       chip_select_n_out,
   output logic                   pair_select_out,
   output logic                   transfer_acknowledge_n_out,
   output logic [DATA_W-1:0]      result_first_out,
   output logic [DATA_W-1:0]      result_second_out,
   output logic                   result_valid_out,
   output logic                   ready_out
);
   ////////////////////////////////////////////////////////////////
   // State machine
   typedef enum {ST_IDLE, ST_START, ST_CONV, ST_RD1, ST_GAP, ST_RD2, ST_GUARD} dahrp_state_type;
   dahrp_state_type state_r;   // Current state
   dahrp_state_type state_nxt; // Next state

   // Pin synchronisers
   logic busy_s1_r, busy_s2_r, busy_s3_r;    // Busy sync and history
   logic ext_s1_r, ext_s2_r, ext_s3_r;       // External start sync
   logic [DATA_W-1:0] data_s1_r, data_s2_r;  // Data bus sync
   // Output next values, latches and timer signals
   logic cstart_nxt, rd_nxt, ack_nxt, valid_nxt;
   logic [N_DEV-1:0] cs_r, cs_nxt;
   logic [SEL_W-1:0] dev_r;                  // Latched device choice
   logic pair_r;                             // Latched pair choice
   logic fixed_r;                            // Latched wait mode
   logic wait_state_r;                       // Inserted wait state
   logic tmr_load;                           // Timer load pulse
   logic [TMR_W-1:0] tmr_count;              // Timer load value
   logic tmr_done;                           // Timer expired

   ////////////////////////////////////////////////////////////////
   // Decoding
   wire busy_fall  = busy_s3_r && !busy_s2_r;
   wire ext_fall   = ext_s3_r && !ext_s2_r;
   wire conv_done  = fixed_r ? tmr_done : busy_fall;
   wire go_start   = (state_r == ST_IDLE) && start_req_in;
   wire go_ext     = (state_r == ST_IDLE) && ext_fall;
   wire in_read    = (state_r == ST_RD1) || (state_r == ST_RD2);
   wire rd_finish  = in_read && tmr_done && wait_state_r;

   // One-hot chip select decode, active low
   function automatic logic [N_DEV-1:0] dahrp_decode(input logic [SEL_W-1:0] sel);
      dahrp_decode = '1;
      for (int i = 0; i < N_DEV; i++) begin
         if (sel == i[SEL_W-1:0]) begin
            dahrp_decode[i] = 1'b0;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      state_nxt = state_r;
      tmr_load  = 1'b0;
      tmr_count = '0;
      case (state_r)
         ST_IDLE: begin
            if (go_start) begin
               state_nxt = ST_START;
               tmr_load  = 1'b1;
               tmr_count = TMR_W'(START_LOW_CYC);
            end else if (go_ext) begin
               state_nxt = ST_CONV;
               tmr_load  = 1'b1;
               tmr_count = TMR_W'(FIXED_WAIT_CYC);
            end
         end
         ST_START: begin
            if (tmr_done) begin
               state_nxt = ST_CONV;
               tmr_load  = 1'b1;
               tmr_count = TMR_W'(FIXED_WAIT_CYC);
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               state_nxt = ST_RD1;
               tmr_load  = 1'b1;
               tmr_count = TMR_W'(READ_LOW_CYC);
            end
         end
         ST_RD1: begin
            if (rd_finish) begin
               state_nxt = ST_GAP;
               tmr_load  = 1'b1;
               tmr_count = TMR_W'(READ_GAP_CYC);
            end
         end
         ST_GAP: begin
            if (tmr_done) begin
               state_nxt = ST_RD2;
               tmr_load  = 1'b1;
               tmr_count = TMR_W'(READ_LOW_CYC);
            end
         end
         ST_RD2: begin
            if (rd_finish) begin
               state_nxt = ST_GUARD;
               tmr_load  = 1'b1;
               tmr_count = TMR_W'(READ_GUARD_CYC);
            end
         end
         ST_GUARD: begin
            if (tmr_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Pin values for the next cycle
   assign cstart_nxt = !(state_nxt == ST_START);
   assign rd_nxt     = !(state_nxt == ST_RD1 || state_nxt == ST_RD2);
   assign cs_nxt     = rd_nxt ? '1 : dahrp_decode(dev_r);
   assign ack_nxt    = &cs_nxt;
   assign valid_nxt  = (state_r == ST_RD2) && rd_finish;

   ////////////////////////////////////////////////////////////////
   // Timer for pulse widths and waits
   dahrp_timer #(.W(TMR_W)) u_timer (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .load_in    (tmr_load),
      .count_in   (tmr_count),
      .done_out   (tmr_done)
   );

   ////////////////////////////////////////////////////////////////
   // Input synchronisers
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_s1_r <= 1'b0;
         busy_s2_r <= 1'b0;
         busy_s3_r <= 1'b0;
         ext_s1_r  <= PIN_IDLE;
         ext_s2_r  <= PIN_IDLE;
         ext_s3_r  <= PIN_IDLE;
         data_s1_r <= '0;
         data_s2_r <= '0;
      end else begin
         busy_s1_r <= busy_in;
         busy_s2_r <= busy_s1_r;
         busy_s3_r <= busy_s2_r;
         ext_s1_r  <= ext_start_n_in;
         ext_s2_r  <= ext_s1_r;
         ext_s3_r  <= ext_s2_r;
         data_s1_r <= data_in;
         data_s2_r <= data_s1_r;
      end
   end

   // State and request latches
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r      <= ST_IDLE;
         dev_r        <= '0;
         pair_r       <= 1'b0;
         fixed_r      <= 1'b0;
         wait_state_r <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         wait_state_r <= in_read && tmr_done && !wait_state_r;
         if (state_r == ST_IDLE) begin
            dev_r   <= dev_sel_in;
            pair_r  <= pair_sel_in;
            fixed_r <= use_fixed_wait_in;
         end
      end
   end

   // Pin outputs
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         conversion_start_n_out     <= PIN_IDLE;
         read_n_out                 <= PIN_IDLE;
         chip_select_n_out          <= '1;
         pair_select_out            <= 1'b0;
         transfer_acknowledge_n_out <= PIN_IDLE;
         ready_out                  <= 1'b0;
      end else begin
         conversion_start_n_out     <= cstart_nxt;
         read_n_out                 <= rd_nxt;
         chip_select_n_out          <= cs_nxt;
         pair_select_out            <= pair_r;
         transfer_acknowledge_n_out <= ack_nxt;
         ready_out                  <= (state_nxt == ST_IDLE);
      end
   end

   // Result capture at end of each read
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         result_first_out  <= '0;
         result_second_out <= '0;
         result_valid_out  <= 1'b0;
      end else begin
         result_valid_out <= valid_nxt;
         if (state_r == ST_RD1 && rd_finish) begin
            result_first_out <= data_s2_r;
         end
         if (state_r == ST_RD2 && rd_finish) begin
            result_second_out <= data_s2_r;
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/dahrp_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter that flags when a loaded count has expired
module dahrp_timer
   import dahrp_pkg::*;
#(
   parameter int unsigned W = TMR_W
) (
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] count_in,
   output logic              done_out
);
   ////////////////////////////////////////////////////////////////
   logic [W-1:0] cnt_r;   // Remaining cycles
   logic [W-1:0] cnt_nxt; // Next count
   logic         done_nxt;

   // Load, or count down to zero
   assign cnt_nxt  = load_in ? count_in : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
   assign done_nxt = !load_in && (cnt_nxt == '0);

   // Count register
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r    <= '0;
         done_out <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         done_out <= done_nxt;
      end
   end
endmodule
`default_nettype wire

// file: inc/dahrp_pkg.sv
package dahrp_pkg;
   // System clock rate
   localparam int unsigned CLK_FREQ_HZ       = 40000000;
   localparam int unsigned CLK_PERIOD_PS     = 1000000000 / (CLK_FREQ_HZ / 1000);
   // Data bus width of the converter
   localparam int unsigned DATA_W            = 14;
   // Least gap from last read to next start edge
   localparam int unsigned READ_GUARD_NS     = 400;
   localparam int unsigned READ_GUARD_CYC    = (READ_GUARD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Conversion time, in ns
   localparam int unsigned CONV_TIME_NS      = 5200;
   localparam int unsigned CONV_TIME_CYC     = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Start pulse low width, in ns
   localparam int unsigned START_LOW_NS      = 100;
   localparam int unsigned START_LOW_CYC     = (START_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Read strobe low width, in ns
   localparam int unsigned READ_LOW_NS       = 100;
   localparam int unsigned READ_LOW_CYC      = (READ_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Gap between the two reads, in ns
   localparam int unsigned READ_GAP_NS       = 50;
   localparam int unsigned READ_GAP_CYC      = (READ_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Fixed wait margin over conversion time
   localparam int unsigned FIXED_WAIT_CYC    = CONV_TIME_CYC + 8;
   // Timer width
   localparam int unsigned TMR_W             = 12;
   // Reset values of the pins
   localparam logic        PIN_IDLE          = 1'b1;
endpackage
